// File: rtl/overtemp_fault_response.sv
// over-temperature threshold, response byte and shutdown/retry sequencer
// How it works
// - a 16-bit read/write threshold in linear format holds the trip point.
// - action 00 in the top two bits keeps the output running on a fault.
// - action 01 runs on for the delay, then follows the retry field if hot.
// - action 10 turns the output off at once and follows the retry field.
// - action 11 holds the output off until a clear, reset or off/on cycle.
// - retry field zero means no restart; the output stays off until cleared.
// - retry values one to six restart that often, then latch off.
// - attempt starts are spaced by the delay count times the delay unit.
// - retry value seven restarts forever until off, reset or another fault.
// - the delay field n means two to the power n delay units.
`timescale 1ns/1ps
`include "overtemp_fault_regs.svh"

module overtemp_fault_response (
    input wire logic mclk, // 125 MHz controller clock
    input wire logic rst_n, // async bias-power reset, active low
    input wire overtemp_pkg::cmd_req_t cmd_req, // command from link engine
    output overtemp_pkg::cmd_rsp_t cmd_rsp, // registered read answer
    input wire logic [15:0] temp_linear, // measured temperature, linear
    input wire logic unit_tick, // one pulse per delay unit
    input wire logic ctrl_pin, // remote on/off pin, high is on
    input wire logic op_on, // on/off state of the operation command
    input wire logic clear_faults, // clear-faults pulse
    input wire logic status_clr, // pulse clearing the status bit and releasing a latched fault
    input wire logic other_fault, // another fault latches off a sequence already under way, not plain running
    output logic out_en, // power stage enable
    output logic fault_status // sticky over-temperature status bit
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // linear value scaled to a signed fixed point with 16 fraction bits
    function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
        logic signed [47:0] mant;
        logic signed [5:0] sh;
        mant = 48'(signed'(v[`OT_LIN_MANT_HI:0]));
        sh = 6'(signed'(v[`OT_LIN_EXP_HI:`OT_LIN_EXP_LO])) + 6'(`OT_FIX_FRAC);
        lin_to_fix = mant <<< sh;
    endfunction

    // count of units for a three-bit delay field
    function automatic logic [7:0] unit_count(input logic [2:0] f);
        unit_count = 8'h01 << f;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchroniser

    logic rst_meta_ff, rst_sync_n;
    logic ctrl_meta_ff, ctrl_sync_ff;

    // async assert, clocked release
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_n <= rst_meta_ff;
        end
    end

    // pin arrives from outside the clock domain
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            ctrl_meta_ff <= 1'b0;
            ctrl_sync_ff <= 1'b0;
        end
        else
        begin
            ctrl_meta_ff <= ctrl_pin;
            ctrl_sync_ff <= ctrl_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [15:0] threshold_ff;
    logic [7:0] action_ff;
    overtemp_pkg::cmd_rsp_t rsp_ff;

    // command writes
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            threshold_ff <= `OT_THRESHOLD_RST;
            action_ff <= `OT_ACTION_RST;
        end
        else if (cmd_req.wr)
        begin
            if (cmd_req.code == `OT_CMD_THRESHOLD)
                threshold_ff <= cmd_req.wdata;
            if (cmd_req.code == `OT_CMD_ACTION)
                action_ff <= cmd_req.wdata[7:0];
        end
    end

    // reads answer one cycle later; unknown codes read zero
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            rsp_ff <= '0;
        else
        begin
            rsp_ff.valid <= cmd_req.rd;
            if (cmd_req.rd && cmd_req.code == `OT_CMD_THRESHOLD)
                rsp_ff.data <= threshold_ff;
            else if (cmd_req.rd && cmd_req.code == `OT_CMD_ACTION)
                rsp_ff.data <= {8'h00, action_ff};
            else
                rsp_ff.data <= 16'h0000;
        end
    end

    assign cmd_rsp = rsp_ff;

    ////////////////////////////////////////////////////////////////////////
    // fault detection and sequencer

    logic [1:0] act;
    logic [2:0] retry;
    logic [2:0] dly;
    logic fault_now, on_cmd, clr_any, cnt_done, tries_left;
    overtemp_pkg::fault_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff;
    logic [2:0] tries_ff;
    logic out_en_ff, status_ff;

    assign act = action_ff[`OT_ACT_HI:`OT_ACT_LO];
    assign retry = action_ff[`OT_RETRY_HI:`OT_RETRY_LO];
    assign dly = action_ff[`OT_DELAY_HI:`OT_DELAY_LO];
    // signed compare so sub-zero readings never trip a positive limit
    assign fault_now = lin_to_fix(temp_linear) >= lin_to_fix(threshold_ff);
    assign on_cmd = ctrl_sync_ff & op_on;
    assign clr_any = clear_faults | status_clr;
    assign cnt_done = cnt_ff >= unit_count(dly);
    assign tries_left = (retry == `OT_RETRY_FOREVER) || (tries_ff < retry);

    // next state; being commanded off ends every sequence
    always_comb
    begin
        nxt_state = state_ff;
        if (!on_cmd)
            nxt_state = overtemp_pkg::ST_RUN;
        else if (other_fault && state_ff != overtemp_pkg::ST_RUN)
            nxt_state = overtemp_pkg::ST_LATCH;
        else
        begin
            unique case (state_ff)
                overtemp_pkg::ST_RUN:
                    if (fault_now)
                    begin
                        unique case (act)
                            `OT_ACT_IGNORE: nxt_state = overtemp_pkg::ST_RUN;
                            `OT_ACT_RUN_ON: nxt_state = overtemp_pkg::ST_HOLD;
                            `OT_ACT_RETRY: nxt_state =
                                (retry == `OT_RETRY_NONE) ?
                                overtemp_pkg::ST_LATCH : overtemp_pkg::ST_WAIT;
                            `OT_ACT_LATCH: nxt_state = overtemp_pkg::ST_LATCH;
                        endcase
                    end
                overtemp_pkg::ST_HOLD:
                    if (cnt_done)
                    begin
                        if (!fault_now)
                            nxt_state = overtemp_pkg::ST_RUN;
                        else if (retry == `OT_RETRY_NONE)
                            nxt_state = overtemp_pkg::ST_LATCH;
                        else
                            nxt_state = overtemp_pkg::ST_WAIT;
                    end
                overtemp_pkg::ST_WAIT:
                    if (cnt_done)
                        nxt_state = tries_left ?
                            overtemp_pkg::ST_TRY : overtemp_pkg::ST_LATCH;
                overtemp_pkg::ST_TRY:
                    if (fault_now)
                        nxt_state = overtemp_pkg::ST_WAIT;
                    else if (cnt_done)
                        nxt_state = overtemp_pkg::ST_RUN;
                overtemp_pkg::ST_LATCH:
                    if (clr_any)
                        nxt_state = overtemp_pkg::ST_RUN;
                default: nxt_state = overtemp_pkg::ST_LATCH;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state_ff <= overtemp_pkg::ST_RUN;
        else
            state_ff <= nxt_state;
    end

    // unit counter: restarts on every state change but try to wait, so a try keeps its
    // count while it falls back to wait, giving start-to-start spacing
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            cnt_ff <= 8'h00;
        else if (nxt_state != state_ff &&
                 !(state_ff == overtemp_pkg::ST_TRY &&
                   nxt_state == overtemp_pkg::ST_WAIT))
            cnt_ff <= 8'h00;
        else if (unit_tick && !cnt_done)
            cnt_ff <= cnt_ff + 8'h01;
    end

    // restart attempts made since the fault began
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tries_ff <= 3'h0;
        else if (nxt_state == overtemp_pkg::ST_RUN)
            tries_ff <= 3'h0;
        else if (state_ff == overtemp_pkg::ST_WAIT &&
                 nxt_state == overtemp_pkg::ST_TRY &&
                 retry != `OT_RETRY_FOREVER)
            tries_ff <= tries_ff + 3'h1;
    end

    // output enable follows the state it enters
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            out_en_ff <= 1'b0;
        else
            out_en_ff <= on_cmd && (nxt_state == overtemp_pkg::ST_RUN ||
                                    nxt_state == overtemp_pkg::ST_HOLD ||
                                    nxt_state == overtemp_pkg::ST_TRY);
    end

    // sticky status; a fault in the clearing cycle keeps the bit set
    always_ff @(posedge mclk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            status_ff <= 1'b0;
        else if (fault_now)
            status_ff <= 1'b1;
        else if (clr_any)
            status_ff <= 1'b0;
    end

    assign out_en = out_en_ff;
    assign fault_status = status_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    sequence hot_in_run;
        state_ff == overtemp_pkg::ST_RUN && on_cmd && fault_now && !other_fault;
    endsequence

    sequence hold_expired_hot;
        state_ff == overtemp_pkg::ST_HOLD && cnt_done && fault_now &&
        on_cmd && !other_fault;
    endsequence

    ignore_keeps_on_a: assert property ((hot_in_run and act == `OT_ACT_IGNORE) |=> out_en_ff)
        else $error("output dropped while fault ignored");
    disable_now_a: assert property ((hot_in_run and act == `OT_ACT_RETRY) |=> !out_en_ff)
        else $error("output not disabled on fault");
    hold_then_act_a: assert property ((hold_expired_hot and retry != `OT_RETRY_NONE) |=> state_ff == overtemp_pkg::ST_WAIT && !out_en_ff)
        else $error("run-on delay did not lead to retry");
    latch_stays_a: assert property ((state_ff == overtemp_pkg::ST_LATCH && on_cmd && !clr_any) |=> !out_en_ff && state_ff == overtemp_pkg::ST_LATCH)
        else $error("latched fault released without clear");
    no_retry_a: assert property ((hot_in_run and act == `OT_ACT_RETRY && retry == `OT_RETRY_NONE) |=> state_ff == overtemp_pkg::ST_LATCH)
        else $error("restart attempted with zero retries");
    retry_limit_a: assert property ((state_ff == overtemp_pkg::ST_WAIT && cnt_done && on_cmd && !other_fault && retry != `OT_RETRY_FOREVER && tries_ff >= retry) |=> state_ff == overtemp_pkg::ST_LATCH)
        else $error("retry count exceeded");
    spacing_a: assert property ((state_ff == overtemp_pkg::ST_WAIT && nxt_state == overtemp_pkg::ST_TRY) |-> cnt_ff == unit_count(dly))
        else $error("restart not spaced by delay units");
    forever_retry_a: assert property ((state_ff == overtemp_pkg::ST_WAIT && cnt_done && on_cmd && !other_fault && retry == `OT_RETRY_FOREVER) |=> state_ff == overtemp_pkg::ST_TRY ##0 out_en_ff)
        else $error("continuous retry stopped");
    off_ends_a: assert property (!on_cmd |=> !out_en_ff && state_ff == overtemp_pkg::ST_RUN)
        else $error("output on while commanded off");
    status_set_a: assert property (fault_now |=> status_ff ##1 (status_ff || !$past(fault_now)))
        else $error("fault not recorded in status");

endmodule

// File: rtl/overtemp_fault_regs.svh
// command codes, field positions, reset values and widths of the fault block
`ifndef OVERTEMP_FAULT_REGS_SVH
`define OVERTEMP_FAULT_REGS_SVH
`define OT_CMD_THRESHOLD 8'h4f
`define OT_CMD_ACTION 8'h50
`define OT_THRESHOLD_RST 16'hebe8
`define OT_ACTION_RST 8'h80
`define OT_ACT_HI 7
`define OT_ACT_LO 6
`define OT_RETRY_HI 5
`define OT_RETRY_LO 3
`define OT_DELAY_HI 2
`define OT_DELAY_LO 0
`define OT_ACT_IGNORE 2'h0
`define OT_ACT_RUN_ON 2'h1
`define OT_ACT_RETRY 2'h2
`define OT_ACT_LATCH 2'h3
`define OT_RETRY_NONE 3'h0
`define OT_RETRY_FOREVER 3'h7
`define OT_LIN_EXP_HI 15
`define OT_LIN_EXP_LO 11
`define OT_LIN_MANT_HI 10
`define OT_FIX_FRAC 16
`endif

// File: rtl/overtemp_pkg.sv
// shared types of the over-temperature fault block
package overtemp_pkg;
    // one management transaction from the link engine
    typedef struct packed {
        logic [7:0] code;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } cmd_req_t;

    // read answer back to the link engine
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } cmd_rsp_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_HOLD = 3'b001,
        ST_WAIT = 3'b010,
        ST_TRY = 3'b011,
        ST_LATCH = 3'b100
    } fault_state_t;
endpackage

// File: dv/pmbus_host_model.sv
// management-link host issuing word accesses to the fault block
`timescale 1ns/1ps

module pmbus_host_model (
    input wire logic mclk, // controller clock
    output overtemp_pkg::cmd_req_t cmd_req, // request to the block
    input wire overtemp_pkg::cmd_rsp_t cmd_rsp // registered read answer
);
    ////////////////////////////////////////////////////////////////////////
    // idle lines carry the inverse of the last value, never a stale copy
    initial cmd_req = '0;

    // one strobe cycle; a read waits one edge for the registered answer
    task automatic access(input logic [7:0] c, input logic w,
        input logic [15:0] d, output logic [15:0] rdata);
        @(negedge mclk);
        cmd_req = '{code: c, wr: w, rd: !w, wdata: d};
        @(posedge mclk);
        @(negedge mclk);
        cmd_req = '{code: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
        rdata = 16'h0000;
        if (!w)
        begin
            @(posedge mclk);
            rdata = cmd_rsp.data;
        end
    endtask
endmodule

// File: dv/tb.sv
// self-checking bench of the over-temperature fault block
`timescale 1ns/1ps
`include "overtemp_fault_regs.svh"

module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    overtemp_pkg::cmd_req_t cmd_req;
    overtemp_pkg::cmd_rsp_t cmd_rsp;
    logic [15:0] temp_linear = 16'h0000;
    logic unit_tick = 1'b0;
    logic [1:0] tdiv = 2'h0;
    logic ctrl_pin = 1'b1;
    logic op_on = 1'b1;
    logic clear_faults = 1'b0;
    logic status_clr = 1'b0;
    logic other_fault = 1'b0;
    logic out_en;
    logic fault_status;
    logic probe = 1'b0;
    logic [1:0] probe_sel = 2'h0;
    logic prev_en = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] obs;
    logic [15:0] rd_unused;
    logic [31:0] seed = 32'hcf8d;
    int n_mismatch = 0;
    int n_compared = 0;
    int tk = 0;
    int tk_rise = 0;
    int gap = 0;
    int rises = 0;
    int d;

    always #4 mclk = ~mclk;

    overtemp_fault_response overtemp_fault_response_inst (.mclk(mclk),
        .rst_n(rst_n), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp),
        .temp_linear(temp_linear), .unit_tick(unit_tick),
        .ctrl_pin(ctrl_pin), .op_on(op_on), .clear_faults(clear_faults),
        .status_clr(status_clr), .other_fault(other_fault),
        .out_en(out_en), .fault_status(fault_status));
    pmbus_host_model pmbus_host_model_inst (.mclk(mclk), .cmd_req(cmd_req),
        .cmd_rsp(cmd_rsp));

    ////////////////////////////////////////////////////////////////////////
    // delay unit of four cycles keeps retry runs short
    always @(negedge mclk)
    begin
        tdiv <= tdiv + 2'h1;
        unit_tick <= (tdiv == 2'h3);
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic rd_expect(input logic [7:0] c, input logic [15:0] v);
        exp_q.push_back(v);
        pmbus_host_model_inst.access(c, 1'b0, 16'h0000, rd_unused);
    endtask

    // probe: 0 out_en, 1 status, 2 rise count, 3 ticks between rises
    task automatic probe_at(input logic [1:0] s, input logic [15:0] v);
        @(negedge mclk);
        exp_q.push_back(v);
        probe_sel = s;
        probe = 1'b1;
        @(negedge mclk);
        probe = 1'b0;
    endtask

    task automatic set_act(input logic [1:0] a, input logic [2:0] r,
        input logic [2:0] dl);
        pmbus_host_model_inst.access(`OT_CMD_ACTION, 1'b1,
            {8'h00, a, r, dl}, rd_unused);
    endtask

    // hot values start at the threshold itself, the awkward boundary
    task automatic heat(input logic h);
        seed = xs(seed);
        temp_linear = h ? 16'd100 + 16'(seed % 924) : 16'(seed % 100);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        cycles(1);
        s = 1'b0;
        cycles(4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: oldest note checked when a read answer or a probe shows
    always @(posedge mclk)
    begin
        if (unit_tick)
            tk++;
        if (out_en === 1'b1 && prev_en !== 1'b1)
        begin
            gap = tk - tk_rise;
            tk_rise = tk;
            rises++;
        end
        prev_en = out_en;
        obs = probe_sel == 2'h0 ? {15'h0000, out_en} :
              probe_sel == 2'h1 ? {15'h0000, fault_status} :
              probe_sel == 2'h2 ? rises[15:0] : gap[15:0];
        if (cmd_rsp.valid === 1'b1)
            check(cmd_rsp.data, exp_q.pop_front());
        if (probe)
            check(obs, exp_q.pop_front());
    end

    // watchdog sized well past the whole sequence
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        print_verdict();
    end

    initial
    begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        cycles(4);
        rd_expect(`OT_CMD_THRESHOLD, `OT_THRESHOLD_RST);
        rd_expect(`OT_CMD_ACTION, {8'h00, `OT_ACTION_RST});
        pmbus_host_model_inst.access(`OT_CMD_THRESHOLD, 1'b1, 16'h0064,
            rd_unused);
        pmbus_host_model_inst.access(8'h51, 1'b1, 16'h1234, rd_unused);
        rd_expect(`OT_CMD_THRESHOLD, 16'h0064);
        rd_expect(8'h51, 16'h0000);
        $display("test registers done");
        set_act(`OT_ACT_IGNORE, `OT_RETRY_NONE, 3'h0);
        temp_linear = 16'h0064;
        cycles(40);
        probe_at(2'h0, 16'h0001);
        probe_at(2'h1, 16'h0001);
        heat(1'b0);
        pulse(status_clr);
        probe_at(2'h1, 16'h0000);
        $display("test ignore done");
        set_act(`OT_ACT_LATCH, `OT_RETRY_NONE, 3'h0);
        heat(1'b1);
        probe_at(2'h0, 16'h0000);
        heat(1'b0);
        cycles(20);
        probe_at(2'h0, 16'h0000);
        pulse(op_on);
        op_on = 1'b0;
        cycles(4);
        op_on = 1'b1;
        cycles(4);
        probe_at(2'h0, 16'h0001);
        $display("test latch done");
        set_act(`OT_ACT_RETRY, `OT_RETRY_NONE, 3'h1);
        heat(1'b1);
        probe_at(2'h0, 16'h0000);
        cycles(60);
        probe_at(2'h0, 16'h0000);
        heat(1'b0);
        pulse(clear_faults);
        probe_at(2'h0, 16'h0001);
        // every bounded retry count with a random delay field
        for (int r = 1; r <= 6; r++)
        begin
            seed = xs(seed);
            d = seed % 3;
            set_act(`OT_ACT_RETRY, 3'(r), 3'(d));
            rises = 0;
            heat(1'b1);
            cycles((r + 2) * 4 * (1 << d) + 16);
            probe_at(2'h2, 16'(r));
            if (r > 1)
                probe_at(2'h3, 16'(1 << d));
            probe_at(2'h0, 16'h0000);
            heat(1'b0);
            pulse(status_clr);
            probe_at(2'h0, 16'h0001);
        end
        $display("test retry done");
        set_act(`OT_ACT_RUN_ON, `OT_RETRY_NONE, 3'h2);
        heat(1'b1);
        probe_at(2'h0, 16'h0001);
        cycles(8);
        probe_at(2'h0, 16'h0001);
        cycles(24);
        probe_at(2'h0, 16'h0000);
        heat(1'b0);
        pulse(clear_faults);
        probe_at(2'h0, 16'h0001);
        // delay that ends cool keeps the output running
        set_act(`OT_ACT_RUN_ON, `OT_RETRY_NONE, 3'h2);
        heat(1'b1);
        cycles(4);
        heat(1'b0);
        cycles(30);
        probe_at(2'h0, 16'h0001);
        // delay that ends hot hands over to one retry, then latches
        set_act(`OT_ACT_RUN_ON, 3'h1, 3'h0);
        rises = 0;
        heat(1'b1);
        cycles(30);
        probe_at(2'h2, 16'h0001);
        probe_at(2'h0, 16'h0000);
        heat(1'b0);
        pulse(clear_faults);
        // cooling while off lets the first restart succeed
        set_act(`OT_ACT_RETRY, 3'h2, 3'h0);
        heat(1'b1);
        cycles(2);
        heat(1'b0);
        cycles(30);
        probe_at(2'h0, 16'h0001);
        $display("test run-on done");
        set_act(`OT_ACT_RETRY, `OT_RETRY_FOREVER, 3'h0);
        heat(1'b1);
        cycles(80);
        rises = 0;
        // forty watched edges hold exactly ten one-unit attempts
        cycles(38);
        probe_at(2'h2, 16'd10);
        pulse(other_fault);
        heat(1'b0);
        cycles(30);
        probe_at(2'h0, 16'h0000);
        pulse(clear_faults);
        probe_at(2'h0, 16'h0001);
        heat(1'b1);
        cycles(20);
        ctrl_pin = 1'b0;
        cycles(6);
        rises = 0;
        cycles(30);
        probe_at(2'h2, 16'h0000);
        probe_at(2'h0, 16'h0000);
        ctrl_pin = 1'b1;
        heat(1'b0);
        cycles(6);
        probe_at(2'h0, 16'h0001);
        $display("test forever done");
        set_act(`OT_ACT_LATCH, `OT_RETRY_NONE, 3'h0);
        heat(1'b1);
        cycles(4);
        rst_n = 1'b0;
        heat(1'b0);
        cycles(2);
        rst_n = 1'b1;
        cycles(6);
        probe_at(2'h0, 16'h0001);
        rd_expect(`OT_CMD_ACTION, {8'h00, `OT_ACTION_RST});
        cycles(4);
        $display("test reset done");
        print_verdict();
    end
endmodule
